/* File: hdl/cal_limits_regs.vh */
// Command codes, reset values, field positions and fixed-point constants
// for the current and temperature calibration and limit block.
// Assumes fixed-point readings with 16 fraction bits.
`ifndef CAL_LIMITS_REGS_VH
`define CAL_LIMITS_REGS_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_PAGE          8'h00
`define CMD_CLEAR_FAULTS  8'h03
`define CMD_SENSE_GAIN    8'h38
`define CMD_OC_FAULT      8'h46
`define CMD_OC_WARN       8'h4A
`define CMD_IIN_WARN      8'h5D
`define CMD_PWM_MODE      8'hD4
`define CMD_IIN_OFFSET    8'hE9
`define CMD_GAIN_TC       8'hF6
`define CMD_TEMP_SLOPE    8'hF8
`define CMD_TEMP_OFFSET   8'hF9
`define PAGE_ALL          8'hFF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SENSE_GAIN    16'hBB9A
`define RST_OC_FAULT      16'hDBB8
`define RST_OC_WARN       16'hDA80
`define RST_IIN_WARN      16'hD280
`define RST_IIN_OFFSET    16'h9333
`define RST_GAIN_TC       16'h0F3C
`define RST_TEMP_SLOPE    16'h4000
`define RST_TEMP_OFFSET   16'h8000
`define RST_PWM_MODE      8'h00
`define RST_PAGE          8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PWM_RANGE_BIT     7
`define SUM_NONE_BIT      0
`define SUM_IOUT_BIT      1
`define SUM_OTHER_BIT     2
`define SUM_INPUT_BIT     3

// ----------------------------------------------------------------
// Fixed-point and timing constants
// ----------------------------------------------------------------
`define FRAC_BITS         16
`define TEMP_SLOPE_SHIFT  14
`define NOM_TEMP_FIX      64'h0000_0000_001B_0000
`define ZERO_K_FIX        64'h0000_0000_0111_2666
`define PPM_RECIP         64'h0000_0000_0001_0C6F
`define PPM_SHIFT         36
`define RESP_MS           120
`define CLK_MHZ           250

`endif

/* File: hdl/cal_limits.v */
// Calibration registers, temperature compensated current sense gain and
// current limit checking for two channels, behind an SMBus-style slave.
// Assumes readings arrive asynchronously as signed fixed point, 16 fraction bits.
//
// Notes on behaviour
// [R1] Per-channel quiescent input current offset added to input current, default 0x9333.
// [R2] Per-channel current sense gain in milliohms, default 0xBB9A.
// [R3] Sense element temperature coefficient, signed 16-bit ppm/C, default 0x0F3C.
// [R4] Gain scaled by one plus coefficient times (temperature minus 27 C).
// [R5] Compensated gain used for output current and both output limits.
// [R6] Single unpaged input overcurrent warning limit in amperes, default 0xD280.
// [R7] Input overcurrent sets other, input and warning flags; alert unless masked.
// [R8] Reading-based limit crossings detected well within 120 ms.
// [R9] Output overcurrent fault while in current limit; peak limit default 0xDBB8.
// [R10] Range bit 0: peak limit rounds up to 25..50 mV steps over gain.
// [R11] Range bit 1: peak limit rounds up to 37.5..75 mV steps over gain.
// [R12] Current range is bit 7 of the PWM mode configuration.
// [R13] Peak limits follow temperature through the coefficient around 27.0 C.
// [R14] Fault limit bounds the peak current; readback compares average current.
// [R15] Output overcurrent fault ignored during rise and fall ramps.
// [R16] Averaged output current compared with per-channel warning limit, default 0xDA80.
// [R17] Output overcurrent warning sets none-of-above, iout and warning flags; alert unless masked.
// [R18] Temperature slope scaled by N times 2^-14, default 0x4000.
// [R19] Per-channel temperature offset in C, default 0x8000.
// [R20] Host should program about 3900 ppm/C for inductor resistance sensing.
// [R21] Host should use continuous conduction for low-load input current accuracy.
// [R22] Temperature calculation starts from -273.15 so zero offset is no change.
// [R23] Linear words: 5-bit signed exponent above 11-bit signed mantissa.
`timescale 1ns/100ps
`include "cal_limits_regs.vh"

module cal_limits #(
	parameter [6:0] BUS_ADDR = 7'h40
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         reset_i,
	// Serial bus pins
	input  wire         scl_i,
	input  wire         sda_i,
	output wire         sda_o,
	output wire         sda_oe_o,
	output wire         alert_o,
	output wire         alert_oe_o,
	// Alert masks from local logic
	input  wire         mask_iin_i,
	input  wire         mask_iout_i,
	// Per-channel readings and analog status
	input  wire [63:0]  vsense_avg_i,
	input  wire [63:0]  iin_raw_i,
	input  wire [63:0]  temp_raw_i,
	input  wire [1:0]   in_ilim_i,
	input  wire [1:0]   ramp_active_i,
	// Limit results
	output wire [5:0]   ilim_step_o,
	output wire [1:0]   ilim_range_o,
	output wire [1:0]   iout_warn_o,
	output wire [1:0]   oc_fault_o,
	output wire         iin_warn_o,
	output wire [3:0]   status_sum_o
);

	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_RX   = 2'd1;
	localparam [1:0] ST_TX   = 2'd2;

	// Linear word to signed fixed point, 16 fraction bits
	function signed [63:0] lin2fix;
		input [15:0] w;
		reg signed [63:0] m;
		begin
			m = {{53{w[10]}}, w[10:0]};
			lin2fix = m <<< {~w[15], w[14:11]}; // [R23]
		end
	endfunction

	// Sense voltage step in tenths of a millivolt
	function [15:0] step_tenths;
		input       rng;
		input [2:0] k;
		begin
			case ({rng, k})
			4'd0:    step_tenths = 16'h00FA;
			4'd1:    step_tenths = 16'h011E;
			4'd2:    step_tenths = 16'h0141;
			4'd3:    step_tenths = 16'h0165;
			4'd4:    step_tenths = 16'h0189;
			4'd5:    step_tenths = 16'h01AD;
			4'd6:    step_tenths = 16'h01D0;
			4'd7:    step_tenths = 16'h01F4;
			4'd8:    step_tenths = 16'h0177;
			4'd9:    step_tenths = 16'h01AD;
			4'd10:   step_tenths = 16'h01E2;
			4'd11:   step_tenths = 16'h0218;
			4'd12:   step_tenths = 16'h024D;
			4'd13:   step_tenths = 16'h0283;
			4'd14:   step_tenths = 16'h02B8;
			default: step_tenths = 16'h02EE;
			endcase
		end
	endfunction

	// Smallest step whose voltage covers the limit voltage, else top
	function [2:0] pick_step;
		input                rng;
		input signed [63:0]  lim_mv;
		reg signed [63:0]    need;
		integer              k;
		begin
			need = lim_mv * 64'sd10;
			pick_step = 3'd7;
			for (k = 7; k >= 0; k = k - 1) begin
				if ($signed({32'h0000_0000, step_tenths(rng, k[2:0]), 16'h0000}) >= need) begin
					pick_step = k[2:0];
				end
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	reg [15:0] gain_r     [0:1];
	reg [15:0] ocf_r      [0:1];
	reg [15:0] ocw_r      [0:1];
	reg [15:0] iofs_r     [0:1];
	reg [15:0] tc_r       [0:1];
	reg [15:0] tslope_r   [0:1];
	reg [15:0] tofs_r     [0:1];
	reg [7:0]  pwm_r      [0:1];
	reg [15:0] iin_warn_r;
	reg [7:0]  page_r;
	reg        clr_r;

	// ----------------------------------------------------------------
	// Bus pin synchronisers and edge detection
	// ----------------------------------------------------------------
	reg [1:0] scl_s;
	reg [1:0] sda_s;
	reg       scl_d;
	reg       sda_d;
	always @(posedge clk_i) begin
		scl_s <= {scl_s[0], scl_i};
		sda_s <= {sda_s[0], sda_i};
		scl_d <= scl_s[1];
		sda_d <= sda_s[1];
	end
	wire scl_rise = scl_s[1] & ~scl_d;
	wire scl_fall = ~scl_s[1] & scl_d;
	wire bus_start = scl_s[1] & scl_d & sda_d & ~sda_s[1];
	wire bus_stop  = scl_s[1] & scl_d & ~sda_d & sda_s[1];

	// ----------------------------------------------------------------
	// Serial slave: write byte/word, send byte, read word
	// ----------------------------------------------------------------
	reg [1:0]  st_r;
	reg [3:0]  bitcnt_r;
	reg [1:0]  byte_idx_r;
	reg [7:0]  shreg_r;
	reg [7:0]  txsh_r;
	reg [7:0]  cmd_r;
	reg [7:0]  lo_r;
	reg        sda_oe_r;
	reg [15:0] rd_word;
	wire       rch = (page_r == `PAGE_ALL) ? 1'b0 : page_r[0];

	// Read data for the current command and page
	always @* begin
		if (cmd_r == `CMD_PAGE) rd_word = {8'h00, page_r};
		else if (cmd_r == `CMD_SENSE_GAIN) rd_word = gain_r[rch];
		else if (cmd_r == `CMD_OC_FAULT) rd_word = ocf_r[rch];
		else if (cmd_r == `CMD_OC_WARN) rd_word = ocw_r[rch];
		else if (cmd_r == `CMD_IIN_WARN) rd_word = iin_warn_r;
		else if (cmd_r == `CMD_PWM_MODE) rd_word = {8'h00, pwm_r[rch]};
		else if (cmd_r == `CMD_IIN_OFFSET) rd_word = iofs_r[rch];
		else if (cmd_r == `CMD_GAIN_TC) rd_word = tc_r[rch];
		else if (cmd_r == `CMD_TEMP_SLOPE) rd_word = tslope_r[rch];
		else if (cmd_r == `CMD_TEMP_OFFSET) rd_word = tofs_r[rch];
		else rd_word = 16'h0000;
	end

	// Bit engine and register writes
	integer c;
	always @(posedge clk_i) begin
		clr_r <= 1'b0;
		if (reset_i) begin
			st_r       <= ST_IDLE;
			bitcnt_r   <= 4'd0;
			byte_idx_r <= 2'd0;
			shreg_r    <= 8'h00;
			txsh_r     <= 8'h00;
			cmd_r      <= 8'h00;
			lo_r       <= 8'h00;
			sda_oe_r   <= 1'b0;
			page_r     <= `RST_PAGE;
			iin_warn_r <= `RST_IIN_WARN; // [R6]
			for (c = 0; c < 2; c = c + 1) begin
				gain_r[c]   <= `RST_SENSE_GAIN; // [R2]
				ocf_r[c]    <= `RST_OC_FAULT; // [R9]
				ocw_r[c]    <= `RST_OC_WARN; // [R16]
				iofs_r[c]   <= `RST_IIN_OFFSET; // [R1]
				tc_r[c]     <= `RST_GAIN_TC; // [R3]
				tslope_r[c] <= `RST_TEMP_SLOPE; // [R18]
				tofs_r[c]   <= `RST_TEMP_OFFSET; // [R19]
				pwm_r[c]    <= `RST_PWM_MODE;
			end
		end else if (bus_start) begin
			st_r       <= ST_RX;
			bitcnt_r   <= 4'd0;
			byte_idx_r <= 2'd0;
			sda_oe_r   <= 1'b0;
		end else if (bus_stop) begin
			st_r     <= ST_IDLE;
			sda_oe_r <= 1'b0;
		end else if (st_r != ST_IDLE && scl_rise) begin
			shreg_r <= {shreg_r[6:0], sda_s[1]};
			// Ninth bit of a sent byte only; our own address ack keeps the low byte
			if (bitcnt_r == 4'd8 && st_r == ST_TX && !sda_oe_r) begin
				if (sda_s[1]) st_r <= ST_IDLE; // Master ended the read
				else txsh_r <= rd_word[15:8];
			end
			bitcnt_r <= bitcnt_r + 4'd1;
		end else if (st_r != ST_IDLE && scl_fall) begin
			if (bitcnt_r == 4'd9) begin
				bitcnt_r <= 4'd0;
				sda_oe_r <= (st_r == ST_TX) ? ~txsh_r[7] : 1'b0;
			end else if (bitcnt_r == 4'd8 && st_r == ST_TX) begin
				sda_oe_r <= 1'b0;
			end else if (bitcnt_r == 4'd8) begin
				sda_oe_r <= 1'b1;
				if (byte_idx_r != 2'd3) byte_idx_r <= byte_idx_r + 2'd1;
				if (byte_idx_r == 2'd0) begin
					if (shreg_r[7:1] != BUS_ADDR) begin
						st_r     <= ST_IDLE;
						sda_oe_r <= 1'b0;
					end else if (shreg_r[0]) begin
						st_r   <= ST_TX;
						txsh_r <= rd_word[7:0];
					end
				end else if (byte_idx_r == 2'd1) begin
					cmd_r <= shreg_r;
					clr_r <= (shreg_r == `CMD_CLEAR_FAULTS);
				end else if (byte_idx_r == 2'd2) begin
					lo_r <= shreg_r;
					if (cmd_r == `CMD_PAGE) page_r <= shreg_r;
					for (c = 0; c < 2; c = c + 1) begin
						if ((page_r == `PAGE_ALL || page_r[0] == c[0]) &&
						    cmd_r == `CMD_PWM_MODE) pwm_r[c] <= shreg_r;
					end
				end else begin
					if (cmd_r == `CMD_IIN_WARN) iin_warn_r <= {shreg_r, lo_r}; // [R6]
					for (c = 0; c < 2; c = c + 1) begin
						if (page_r == `PAGE_ALL || page_r[0] == c[0]) begin
							if (cmd_r == `CMD_SENSE_GAIN) gain_r[c] <= {shreg_r, lo_r};
							if (cmd_r == `CMD_OC_FAULT) ocf_r[c] <= {shreg_r, lo_r};
							if (cmd_r == `CMD_OC_WARN) ocw_r[c] <= {shreg_r, lo_r};
							if (cmd_r == `CMD_IIN_OFFSET) iofs_r[c] <= {shreg_r, lo_r};
							if (cmd_r == `CMD_GAIN_TC) tc_r[c] <= {shreg_r, lo_r};
							if (cmd_r == `CMD_TEMP_SLOPE) tslope_r[c] <= {shreg_r, lo_r};
							if (cmd_r == `CMD_TEMP_OFFSET) tofs_r[c] <= {shreg_r, lo_r};
						end
					end
				end
			end else if (st_r == ST_TX) begin
				sda_oe_r <= ~txsh_r[3'd7 - bitcnt_r[2:0]];
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-channel calibration and limit checks
	// ----------------------------------------------------------------
	wire [127:0] iin_flat;
	wire [1:0]   iout_warn_w;
	wire [1:0]   oc_fault_w;
	wire [5:0]   step_w;
	wire [1:0]   rng_w;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chan
			reg [31:0]        vs_m, vs_s, ii_m, ii_s, tr_m, tr_s;
			reg               lim_m, lim_s, rmp_m, rmp_s;
			reg signed [63:0] dt_r, geff_r, iin_r;
			reg [2:0]         step_r;
			reg               rng_r, warn_r, fault_r;

			// Readings and status from outside the clock domain
			always @(posedge clk_i) begin
				vs_m  <= vsense_avg_i[32*ch +: 32];
				vs_s  <= vs_m;
				ii_m  <= iin_raw_i[32*ch +: 32];
				ii_s  <= ii_m;
				tr_m  <= temp_raw_i[32*ch +: 32];
				tr_s  <= tr_m;
				lim_m <= in_ilim_i[ch];
				lim_s <= lim_m;
				rmp_m <= ramp_active_i[ch];
				rmp_s <= rmp_m;
			end

			wire signed [63:0] traw  = {{32{tr_s[31]}}, tr_s};
			wire signed [63:0] slope = {{48{tslope_r[ch][15]}}, tslope_r[ch]};
			wire signed [63:0] tcv   = {{48{tc_r[ch][15]}}, tc_r[ch]};
			wire signed [63:0] g     = lin2fix(gain_r[ch]);
			wire signed [63:0] corr  = ((((g * tcv * dt_r) >>> `FRAC_BITS) *
			                           $signed(`PPM_RECIP)) >>> `PPM_SHIFT);
			wire signed [63:0] vs    = {{32{vs_s[31]}}, vs_s};
			wire signed [63:0] warn_mv  = (lin2fix(ocw_r[ch]) * geff_r) >>> `FRAC_BITS;
			wire signed [63:0] fault_mv = (lin2fix(ocf_r[ch]) * geff_r) >>> `FRAC_BITS;
			wire               rng = pwm_r[ch][`PWM_RANGE_BIT]; // [R12]

			// Temperature, compensated gain and limit results
			always @(posedge clk_i) begin
				if (reset_i) begin
					dt_r    <= 64'sd0;
					geff_r  <= 64'sd0;
					iin_r   <= 64'sd0;
					step_r  <= 3'd7;
					rng_r   <= 1'b0;
					warn_r  <= 1'b0;
					fault_r <= 1'b0;
				end else begin
					dt_r <= ((traw * slope) >>> `TEMP_SLOPE_SHIFT) // [R18]
					        + lin2fix(tofs_r[ch]) // [R19]
					        - $signed(`ZERO_K_FIX) // [R22]
					        - $signed(`NOM_TEMP_FIX); // [R4]
					geff_r <= g + corr; // [R4] [R13]
					iin_r  <= {{32{ii_s[31]}}, ii_s} + lin2fix(iofs_r[ch]); // [R1]
					step_r <= pick_step(rng, fault_mv); // [R10] [R11] [R5] [R13]
					rng_r  <= rng;
					// Average reading against limit scaled by gain [R5] [R14] [R16] [R8]
					warn_r <= (vs > warn_mv) | (warn_r & ~clr_r);
					// Peak detector in limit, outside ramps [R9] [R14] [R15]
					fault_r <= (lim_s & ~rmp_s) | (fault_r & ~clr_r);
				end
			end

			assign iin_flat[64*ch +: 64] = iin_r;
			assign iout_warn_w[ch]       = warn_r;
			assign oc_fault_w[ch]        = fault_r;
			assign step_w[3*ch +: 3]     = step_r;
			assign rng_w[ch]             = rng_r;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Input current warning, summary flags and alert
	// ----------------------------------------------------------------
	wire signed [63:0] iin_total = $signed(iin_flat[63:0]) + $signed(iin_flat[127:64]);
	reg        iin_warn_r2;
	reg [3:0]  sum_r;
	reg        alert_oe_r;
	always @(posedge clk_i) begin
		if (reset_i) begin
			iin_warn_r2 <= 1'b0;
			sum_r       <= 4'h0;
			alert_oe_r  <= 1'b0;
		end else begin
			iin_warn_r2 <= (iin_total > lin2fix(iin_warn_r)) | (iin_warn_r2 & ~clr_r); // [R6] [R8]
			// Summary follows the flags; a live event sets its flag again after a clear
			sum_r[`SUM_OTHER_BIT] <= (iin_warn_r2 | sum_r[`SUM_OTHER_BIT]) & ~clr_r; // [R7]
			sum_r[`SUM_INPUT_BIT] <= (iin_warn_r2 | sum_r[`SUM_INPUT_BIT]) & ~clr_r; // [R7]
			sum_r[`SUM_NONE_BIT] <= ((|iout_warn_w) | sum_r[`SUM_NONE_BIT]) & ~clr_r; // [R17]
			sum_r[`SUM_IOUT_BIT] <= ((|iout_warn_w) | sum_r[`SUM_IOUT_BIT]) & ~clr_r; // [R17]
			alert_oe_r <= (iin_warn_r2 & ~mask_iin_i) | // [R7]
			              ((|iout_warn_w) & ~mask_iout_i); // [R17]
		end
	end

	// Output drive
	assign sda_o        = 1'b0;
	assign sda_oe_o     = sda_oe_r;
	assign alert_o      = 1'b0;
	assign alert_oe_o   = alert_oe_r;
	assign ilim_step_o  = step_w;
	assign ilim_range_o = rng_w;
	assign iout_warn_o  = iout_warn_w;
	assign oc_fault_o   = oc_fault_w;
	assign iin_warn_o   = iin_warn_r2;
	assign status_sum_o = sum_r;

endmodule

/* File: bench/cal_limits_chk.sv */
// Checker for the limit block: flag, fault and alert timing at the pins.
// Sees only the top module ports; attached by the bind below.
`timescale 1ns/100ps
module cal_limits_chk (
	// Clock, reset, bus clock, masks
	input wire       clk_i,
	input wire       reset_i,
	input wire       scl_i,
	input wire       mask_iin_i,
	input wire       mask_iout_i,
	// Analog status and results
	input wire [1:0] in_ilim_i,
	input wire [1:0] ramp_active_i,
	input wire [1:0] iout_warn_o,
	input wire [1:0] oc_fault_o,
	input wire       iin_warn_o,
	input wire [3:0] status_sum_o,
	input wire       alert_o,
	input wire       alert_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	property p_fault_set;
		(in_ilim_i[0] && !ramp_active_i[0]) [*8] |-> oc_fault_o[0];
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("no fault in limit");
	property p_ramp_hold;
		ramp_active_i[0] [*4] |-> !$rose(oc_fault_o[0]);
	endproperty
	a_ramp_hold: assert property (p_ramp_hold) else $error("fault in ramp");
	property p_iout_alert;
		iout_warn_o[0] && !mask_iout_i |=> alert_oe_o;
	endproperty
	a_iout_alert: assert property (p_iout_alert) else $error("no output alert");
	property p_iin_alert;
		iin_warn_o && !mask_iin_i |=> alert_oe_o;
	endproperty
	a_iin_alert: assert property (p_iin_alert) else $error("no input alert");
	property p_alert_quiet;
		iout_warn_o == 2'b00 && !iin_warn_o |=> !alert_oe_o;
	endproperty
	a_alert_quiet: assert property (p_alert_quiet) else $error("alert without warn");
	property p_iout_sum;
		$rose(|iout_warn_o) |-> ##[0:2] (status_sum_o[1:0] == 2'b11);
	endproperty
	a_iout_sum: assert property (p_iout_sum) else $error("output summary");
	property p_iin_sum;
		$rose(iin_warn_o) |-> ##[0:2] (status_sum_o[3:2] == 2'b11);
	endproperty
	a_iin_sum: assert property (p_iin_sum) else $error("input summary");
	property p_alert_od;
		alert_o == 1'b0;
	endproperty
	a_alert_od: assert property (p_alert_od) else $error("alert driven high");
	property p_sticky;
		(iout_warn_o[0] && scl_i) [*6] |=> iout_warn_o[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("warn lost");
endmodule
bind cal_limits cal_limits_chk u_chk (.clk_i, .reset_i, .scl_i, .mask_iin_i, .mask_iout_i,
	.in_ilim_i, .ramp_active_i, .iout_warn_o, .oc_fault_o, .iin_warn_o, .status_sum_o,
	.alert_o, .alert_oe_o);

/* File: bench/smbus_host.sv */
// Bus host model: drives the bus clock and pulls the data line low.
// Assumes a pull-up on the data wire, resolved by the bench.
`timescale 1ns/100ps
module smbus_host (
	// Bus pins
	output logic scl_o,
	output logic sda_oe_o,
	input  wire  sda_i
);
	localparam realtime Q = 31.25; // Quarter of a 125 ns bit
	// Idle: clock high and still, data released
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// Bit out, data changed while clock low
	task automatic bo(input logic b);
		sda_oe_o = !b;
		#Q scl_o = 1'b1;
		#(2*Q) scl_o = 1'b0;
		#Q;
	endtask
	// Bit in, sampled mid high phase
	task automatic bi(output logic b);
		sda_oe_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q b = sda_i;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	// Start or repeated start
	task automatic st;
		sda_oe_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b0;
		#Q;
	endtask
	// Stop, line left released
	task automatic sp;
		sda_oe_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b0;
		#Q;
	endtask
	task automatic byo(input logic [7:0] d, inout logic ok);
		logic a;
		for (int i = 7; i >= 0; i--) bo(d[i]);
		bi(a);
		ok = ok & !a;
	endtask
	task automatic byi(output logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--) bi(d[i]);
		bo(last);
	endtask
	// Write of n data bytes, low byte first
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
		input int n, output logic ok);
		ok = 1'b1;
		st();
		byo({a, 1'b0}, ok);
		byo(c, ok);
		if (n > 0) byo(d[7:0], ok);
		if (n > 1) byo(d[15:8], ok);
		sp();
	endtask
	// Word read through a repeated start
	task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d,
		output logic ok);
		ok = 1'b1;
		st();
		byo({a, 1'b0}, ok);
		byo(c, ok);
		st();
		byo({a, 1'b1}, ok);
		byi(d[7:0], 1'b0);
		byi(d[15:8], 1'b1);
		sp();
	endtask
endmodule

/* File: bench/tb_top.sv */
// Bench for the limit block, with the bus host model on the serial pins.
// Assumes the register header and the host model are compiled first.
`timescale 1ns/100ps
`include "cal_limits_regs.vh"
module tb_top;
	typedef struct {string n; logic [15:0] v;} note_t;
	localparam logic [31:0] T27 = 32'h012C_2666; // 300.15 K
	localparam logic [31:0] T127 = 32'h0190_2666; // 400.15 K
	logic        clk = 1'b0, reset = 1'b1, mask_iin = 1'b0, mask_iout = 1'b0;
	logic [63:0] vsense = '0, iin = '0, temp = {T27, T27};
	logic [1:0]  ilim = '0, ramp = '0;
	logic        h_scl, h_oe;
	wire         sda_oe, alert_oe, inwarn;
	wire         sda = !(h_oe || sda_oe);
	wire [5:0]   step;
	wire [1:0]   range, iwarn, fault;
	wire [3:0]   sum;
	int          fail_count = 0, checked = 0, seed = 37;
	note_t       exp_q[$];
	logic [15:0] obs;
	event        obs_ev;
	logic [7:0]  cmd_t [8] = '{`CMD_SENSE_GAIN, `CMD_OC_FAULT, `CMD_OC_WARN, `CMD_IIN_WARN,
		`CMD_IIN_OFFSET, `CMD_GAIN_TC, `CMD_TEMP_SLOPE, `CMD_TEMP_OFFSET};
	logic [15:0] rst_t [8] = '{`RST_SENSE_GAIN, `RST_OC_FAULT, `RST_OC_WARN, `RST_IIN_WARN,
		`RST_IIN_OFFSET, `RST_GAIN_TC, `RST_TEMP_SLOPE, `RST_TEMP_OFFSET};

	cal_limits #(.BUS_ADDR(7'h40)) DUT (
		.clk_i(clk), .reset_i(reset), .scl_i(h_scl), .sda_i(sda), .sda_o(),
		.sda_oe_o(sda_oe), .alert_o(), .alert_oe_o(alert_oe), .mask_iin_i(mask_iin),
		.mask_iout_i(mask_iout), .vsense_avg_i(vsense), .iin_raw_i(iin), .temp_raw_i(temp),
		.in_ilim_i(ilim), .ramp_active_i(ramp), .ilim_step_o(step), .ilim_range_o(range),
		.iout_warn_o(iwarn), .oc_fault_o(fault), .iin_warn_o(inwarn), .status_sum_o(sum));
	smbus_host host (.scl_o(h_scl), .sda_oe_o(h_oe), .sda_i(sda));

	// 250 MHz clock
	always #2 clk = ~clk;

	// ------------------------------------------------------------
	// Expectation queue and compare
	// ------------------------------------------------------------
	task automatic note(input string n, input logic [15:0] e, input logic [15:0] s);
		exp_q.push_back('{n, e});
		obs = s;
		->obs_ev;
		#1; // Compare takes this result before the next one
	endtask
	// Oldest expectation against each result
	always @(obs_ev) begin
		note_t t;
		t = exp_q.pop_front();
		checked++;
		if (obs !== t.v) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", t.n, t.v, obs);
		end
	end
	task automatic rdc(input string n, input logic [7:0] c, input logic [15:0] e);
		logic [15:0] v;
		logic        ok;
		host.rd(7'h40, c, v, ok);
		note(n, e, v);
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input int k);
		logic ok;
		host.wr(7'h40, c, d, k, ok);
	endtask
	task automatic settle;
		repeat (12) @(posedge clk);
	endtask
	task automatic close_out;
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] d;
		logic        ok;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		settle();
		for (int i = 0; i < 8; i++) rdc("reset value", cmd_t[i], rst_t[i]);
		note("default step", 16'd7, {13'd0, step[2:0]});
		host.wr(7'h41, `CMD_OC_WARN, 16'h1234, 2, ok);
		note("foreign ack", 16'h0000, {15'd0, ok});
		rdc("foreign write", `CMD_OC_WARN, `RST_OC_WARN);
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			wr(cmd_t[i], d, 2);
			rdc("read back", cmd_t[i], d);
		end
		rdc("unknown cmd", 8'h7F, 16'h0000);
		// Second reset restores defaults
		@(posedge clk) reset <= 1'b1;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		settle();
		rdc("after reset", `CMD_SENSE_GAIN, `RST_SENSE_GAIN);
		// Paged access: channel 1 written, channel 0 untouched
		wr(`CMD_PAGE, 16'h0001, 1);
		wr(`CMD_SENSE_GAIN, 16'h1357, 2);
		rdc("page", `CMD_PAGE, 16'h0001);
		rdc("paged gain", `CMD_SENSE_GAIN, 16'h1357);
		wr(`CMD_PAGE, 16'h0000, 1);
		rdc("other page gain", `CMD_SENSE_GAIN, `RST_SENSE_GAIN);
		// Peak limit steps, both ranges, then hot
		wr(`CMD_GAIN_TC, 16'h0F3C, 2);
		wr(`CMD_OC_FAULT, 16'hF03C, 2);
		settle();
		note("low step", 16'd1, {13'd0, step[2:0]});
		wr(`CMD_PWM_MODE, 16'h0080, 1);
		settle();
		note("range", 16'd1, {15'd0, range[0]});
		note("high step", 16'd0, {13'd0, step[2:0]});
		wr(`CMD_PWM_MODE, 16'h0000, 1);
		@(posedge clk) temp <= {T27, T127};
		settle();
		note("hot step", 16'd4, {13'd0, step[2:0]});
		// Output warning, masked then unmasked
		@(posedge clk) begin
			temp <= {T27, T27};
			mask_iout <= 1'b1;
			vsense <= {32'h0, 32'h001E_0000};
		end
		settle();
		note("iout quiet", 16'd0, {14'd0, iwarn});
		@(posedge clk) vsense <= {32'h0, 32'h0028_0000};
		settle();
		note("iout warn", 16'h0019, {9'd0, sum, alert_oe, iwarn});
		@(posedge clk) mask_iout <= 1'b0;
		settle();
		note("iout alert", 16'h001D, {9'd0, sum, alert_oe, iwarn});
		@(posedge clk) vsense <= '0;
		wr(`CMD_CLEAR_FAULTS, 16'h0000, 0);
		settle();
		note("cleared", 16'h0000, {9'd0, sum, alert_oe, iwarn});
		// Input warning against summed channels, readings as in continuous conduction
		@(posedge clk) begin
			mask_iin <= 1'b1;
			iin <= {32'h0, 32'h0009_D99A};
		end
		settle();
		note("iin quiet", 16'd0, {15'd0, inwarn});
		@(posedge clk) iin <= {32'h0, 32'h0009_F333};
		settle();
		note("iin warn", 16'h0031, {10'd0, sum, alert_oe, inwarn});
		@(posedge clk) mask_iin <= 1'b0;
		settle();
		note("iin alert", 16'h0033, {10'd0, sum, alert_oe, inwarn});
		// Current limit during and after ramps
		@(posedge clk) begin
			ilim <= 2'b11;
			ramp <= 2'b11;
		end
		settle();
		note("ramp fault", 16'd0, {14'd0, fault});
		@(posedge clk) ramp <= 2'b00;
		settle();
		note("ilim fault", 16'd3, {14'd0, fault});
		close_out();
	end

	// Hang guard
	initial begin
		#350_000;
		fail_count++;
		close_out();
	end
endmodule
